// >>> core/ccs_status_flags.sv
// Transmit and receive status flags of a single-wire control bus controller.
// Assumes the bit engines deliver one-cycle event pulses synchronous to i_ref_clk.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "ccs_defines.svh"

module ccs_status_flags #(
  parameter int unsigned RX_DEPTH   = `CCS_RX_DEPTH,
  parameter int unsigned TMO_CYCLES = `CCS_TMO_CYCLES
) (
  input  wire logic                     i_ref_clk,   // Reference clock, 40 MHz
  input  wire logic                     i_rst_n,     // Async reset, active low
  input  wire ccs_pkg::ccs_reg_req_type i_req,       // Register port request
  input  wire ccs_pkg::ccs_tx_event_type i_tx_ev,    // Transmit engine events
  input  wire ccs_pkg::ccs_rx_event_type i_rx_ev,    // Receive engine events
  output logic [`CCS_DATA_W-1:0]        o_rdata,     // Read data, cycle after read
  output ccs_pkg::ccs_tx_stat_type      o_tx_flags,  // Transmit status flags
  output ccs_pkg::ccs_rx_stat_type      o_rx_flags,  // Receive status flags
  output logic                          o_tx_irq     // Frame done interrupt
);

  localparam int unsigned CW  = $clog2(RX_DEPTH + 1);
  localparam int unsigned TW  = $clog2(TMO_CYCLES + 2);
  localparam logic [TW-1:0] TMO_C = TW'(TMO_CYCLES);

  // ============================================================
  // Parameter checks
  if (TMO_CYCLES < 1) begin : g_tmo_chk
    $error("ccs_status_flags: TMO_CYCLES below 1");
  end

  // ============================================================
  // Helpers
  // Sticky flag update: a set in the same cycle beats a clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // ============================================================
  // Register decode
  logic                  wr_tx_stat;
  logic                  wr_rx_stat;
  logic                  wr_ctrl;
  logic [`CCS_DATA_W-1:0] wd;

  // Address decode of writes
  always_comb begin
    wd         = i_req.wdata;
    wr_tx_stat = i_req.we & (i_req.addr == `CCS_TX_STATUS_OFS);
    wr_rx_stat = i_req.we & (i_req.addr == `CCS_RX_STATUS_OFS);
    wr_ctrl    = i_req.we & (i_req.addr == `CCS_TX_CTRL_OFS);
  end

  // ============================================================
  // Transmit event decode
  logic set_lost;
  logic set_contend;
  logic set_ackf;
  logic set_under;
  logic set_tx_done;

  // Collision split by phase, ack polarity by frame kind
  always_comb begin
    set_lost    = i_tx_ev.collide & i_tx_ev.in_arbitration;
    set_contend = i_tx_ev.collide & ~i_tx_ev.in_arbitration;
    set_ackf    = i_tx_ev.ack_sampled &
                  (i_tx_ev.broadcast ? ~i_tx_ev.ack_bit : i_tx_ev.ack_bit);
    set_under   = i_tx_ev.shift_need & o_tx_flags.tx_queue_empty;
    set_tx_done = (i_tx_ev.block_sent & i_tx_ev.end_of_message_flag) |
                  set_lost | set_under | set_ackf | set_contend;
  end

  // ============================================================
  // Transmit status register
  localparam ccs_pkg::ccs_tx_stat_type tx_rst = ccs_pkg::ccs_tx_stat_type'(`CCS_TX_STATUS_RST);

  // Sticky transmit flags with write-one-to-clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_flags.tx_frame_done     <= tx_rst.tx_frame_done;
      o_tx_flags.contention_error  <= tx_rst.contention_error;
      o_tx_flags.acknowledge_fault <= tx_rst.acknowledge_fault;
      o_tx_flags.tx_underrun       <= tx_rst.tx_underrun;
      o_tx_flags.lost_arbitration  <= tx_rst.lost_arbitration;
    end else begin
      o_tx_flags.tx_frame_done     <= sticky(o_tx_flags.tx_frame_done, set_tx_done,
                                             wr_tx_stat & wd[`CCS_TX_DONE_BIT]);
      o_tx_flags.contention_error  <= sticky(o_tx_flags.contention_error, set_contend,
                                             wr_tx_stat & wd[`CCS_TX_CONTEND_BIT]);
      o_tx_flags.acknowledge_fault <= sticky(o_tx_flags.acknowledge_fault, set_ackf,
                                             wr_tx_stat & wd[`CCS_TX_ACKF_BIT]);
      o_tx_flags.tx_underrun       <= sticky(o_tx_flags.tx_underrun, set_under,
                                             wr_tx_stat & wd[`CCS_TX_UNDER_BIT]);
      o_tx_flags.lost_arbitration  <= sticky(o_tx_flags.lost_arbitration, set_lost,
                                             wr_tx_stat & wd[`CCS_TX_LOST_BIT]);
    end
  end

  // Queue empty: rises on the final pop, drops on a new block
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_flags.tx_queue_empty <= tx_rst.tx_queue_empty;
    end else if (i_tx_ev.queue_push) begin
      o_tx_flags.tx_queue_empty <= 1'b0;
    end else if (i_tx_ev.queue_pop_last) begin
      o_tx_flags.tx_queue_empty <= 1'b1;
    end
  end

  // Bus idle follows the line state, writes have no effect
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_flags.bus_idle <= tx_rst.bus_idle;
    end else begin
      o_tx_flags.bus_idle <= i_tx_ev.bus_idle;
    end
  end

  // ============================================================
  // Receive queue level
  logic [CW-1:0] rx_count;
  logic          rx_accept;
  logic          rx_over;
  logic          rx_next_full;
  logic          rx_next_nempty;

  ccs_rx_level #(
    .DEPTH         (RX_DEPTH),
    .CW            (CW)
  ) u_rx_level (
    .i_ref_clk     (i_ref_clk),
    .i_rst_n       (i_rst_n),
    .i_push        (i_rx_ev.byte_push),
    .i_pop         (i_rx_ev.byte_pop),
    .i_flush       (i_rx_ev.queue_flush),
    .o_count       (rx_count),
    .o_accept      (rx_accept),
    .o_overrun     (rx_over),
    .o_next_full   (rx_next_full),
    .o_next_nempty (rx_next_nempty)
  );

  // ============================================================
  // Line-high timer during reception
  logic [TW-1:0] high_cnt;
  logic          tmo_hit;

  // Pulse once when the line has been high one cycle past the limit
  assign tmo_hit = i_rx_ev.active & i_rx_ev.line_high & (high_cnt == TMO_C);

  // Count consecutive high cycles, saturating past the limit
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      high_cnt <= '0;
    end else if (!(i_rx_ev.active && i_rx_ev.line_high)) begin
      high_cnt <= '0;
    end else if (high_cnt <= TMO_C) begin
      high_cnt <= high_cnt + TW'(1);
    end
  end

  // ============================================================
  // Receive event decode
  logic set_rx_done;

  // Frame done on end of message or any early end
  assign set_rx_done = (i_rx_ev.block_taken & i_rx_ev.end_of_message_flag) |
                       rx_over | i_rx_ev.glitch | tmo_hit;

  // ============================================================
  // Receive status register
  localparam ccs_pkg::ccs_rx_stat_type rx_rst = ccs_pkg::ccs_rx_stat_type'(`CCS_RX_STATUS_RST);

  // Sticky receive flags with write-one-to-clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_flags.rx_frame_done    <= rx_rst.rx_frame_done;
      o_rx_flags.rx_data_ready    <= rx_rst.rx_data_ready;
      o_rx_flags.bus_timeout      <= rx_rst.bus_timeout;
      o_rx_flags.bus_glitch_error <= rx_rst.bus_glitch_error;
      o_rx_flags.rx_overrun       <= rx_rst.rx_overrun;
    end else begin
      o_rx_flags.rx_frame_done    <= sticky(o_rx_flags.rx_frame_done, set_rx_done,
                                            wr_rx_stat & wd[`CCS_RX_DONE_BIT]);
      o_rx_flags.rx_data_ready    <= sticky(o_rx_flags.rx_data_ready, rx_accept,
                                            wr_rx_stat & wd[`CCS_RX_READY_BIT]);
      o_rx_flags.bus_timeout      <= sticky(o_rx_flags.bus_timeout, tmo_hit,
                                            wr_rx_stat & wd[`CCS_RX_TMO_BIT]);
      o_rx_flags.bus_glitch_error <= sticky(o_rx_flags.bus_glitch_error, i_rx_ev.glitch,
                                            wr_rx_stat & wd[`CCS_RX_GLITCH_BIT]);
      o_rx_flags.rx_overrun       <= sticky(o_rx_flags.rx_overrun, rx_over,
                                            wr_rx_stat & wd[`CCS_RX_OVER_BIT]);
    end
  end

  // Queue level flags mirror the occupancy, writes have no effect
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_flags.rx_queue_full      <= rx_rst.rx_queue_full;
      o_rx_flags.rx_queue_not_empty <= rx_rst.rx_queue_not_empty;
    end else begin
      o_rx_flags.rx_queue_full      <= rx_next_full;
      o_rx_flags.rx_queue_not_empty <= rx_next_nempty;
    end
  end

  // ============================================================
  // Control register and interrupt
  logic irq_en;

  // Frame done interrupt enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en <= `CCS_CTRL_RST;
    end else if (wr_ctrl) begin
      irq_en <= wd[`CCS_CTRL_IRQEN_BIT];
    end
  end

  // Interrupt gated by the enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_irq <= 1'b0;
    end else begin
      o_tx_irq <= o_tx_flags.tx_frame_done & irq_en;
    end
  end

  // ============================================================
  // Read data
  logic [`CCS_DATA_W-1:0] next_rdata;

  // Read mux; unmapped addresses and idle cycles give zero
  always_comb begin
    next_rdata = '0;
    if (i_req.re) begin
      unique case (i_req.addr)
        `CCS_TX_STATUS_OFS: next_rdata[6:0] = o_tx_flags;
        `CCS_RX_STATUS_OFS: next_rdata[6:0] = o_rx_flags;
        `CCS_TX_CTRL_OFS:   next_rdata[`CCS_CTRL_IRQEN_BIT] = irq_en;
        default:            next_rdata = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  AST_TX_DONE_EOM: assert property (
    i_tx_ev.block_sent && i_tx_ev.end_of_message_flag |=> o_tx_flags.tx_frame_done
  ) else $error("frame done missing after final block");

  AST_TX_DONE_ABORT: assert property (
    i_tx_ev.collide || (i_tx_ev.shift_need && o_tx_flags.tx_queue_empty) |=> o_tx_flags.tx_frame_done
  ) else $error("frame done missing after abort");

  AST_TX_EMPTY_RISE: assert property (
    i_tx_ev.queue_pop_last && !i_tx_ev.queue_push |=> o_tx_flags.tx_queue_empty
  ) else $error("queue empty did not rise on final pop");

  AST_CONTENTION: assert property (
    i_tx_ev.collide && !i_tx_ev.in_arbitration && !o_tx_flags.lost_arbitration
    |=> o_tx_flags.contention_error && !o_tx_flags.lost_arbitration
  ) else $error("contention after arbitration misfiled");

  AST_ACK_DIRECTED: assert property (
    i_tx_ev.ack_sampled && !i_tx_ev.broadcast && i_tx_ev.ack_bit |=> o_tx_flags.acknowledge_fault
  ) else $error("directed nack not flagged");

  AST_ACK_BROADCAST: assert property (
    i_tx_ev.ack_sampled && i_tx_ev.broadcast && !i_tx_ev.ack_bit |=> o_tx_flags.acknowledge_fault
  ) else $error("broadcast reject not flagged");

  AST_UNDERRUN: assert property (
    i_tx_ev.shift_need && o_tx_flags.tx_queue_empty |=> o_tx_flags.tx_underrun
  ) else $error("underrun not flagged");

  AST_LOST_ARB: assert property (
    i_tx_ev.collide && i_tx_ev.in_arbitration && !o_tx_flags.contention_error
    |=> o_tx_flags.lost_arbitration && !o_tx_flags.contention_error
  ) else $error("arbitration loss misfiled");

  AST_IDLE_FOLLOW: assert property (
    ##1 o_tx_flags.bus_idle == $past(i_tx_ev.bus_idle)
  ) else $error("bus idle does not follow line");

  AST_RX_DONE: assert property (
    (i_rx_ev.block_taken && i_rx_ev.end_of_message_flag) || i_rx_ev.glitch || rx_over
    |=> o_rx_flags.rx_frame_done
  ) else $error("receive frame done missing");

  AST_RX_READY: assert property (
    i_rx_ev.byte_push && !o_rx_flags.rx_queue_full |=> o_rx_flags.rx_data_ready
  ) else $error("data ready missing after push");

  AST_RX_FULL: assert property (
    o_rx_flags.rx_queue_full == (rx_count == CW'(RX_DEPTH))
  ) else $error("full flag disagrees with occupancy");

  AST_RX_NEMPTY: assert property (
    o_rx_flags.rx_queue_not_empty == (rx_count != '0)
  ) else $error("not empty flag disagrees with occupancy");

  AST_TIMEOUT: assert property (
    $rose(o_rx_flags.bus_timeout) |-> $past(high_cnt) == TMO_C
  ) else $error("timeout raised at wrong count");

  AST_OVERRUN: assert property (
    i_rx_ev.byte_push && o_rx_flags.rx_queue_full |=> o_rx_flags.rx_overrun && o_rx_flags.rx_frame_done
  ) else $error("overrun not flagged");

  AST_GLITCH: assert property (
    i_rx_ev.glitch |=> o_rx_flags.bus_glitch_error && o_rx_flags.rx_frame_done
  ) else $error("glitch error not flagged");

  AST_IRQ_GATE: assert property (
    o_tx_irq |-> $past(o_tx_flags.tx_frame_done) && $past(irq_en)
  ) else $error("interrupt without enabled frame done");

  AST_STICKY: assert property (
    o_tx_flags.tx_frame_done && !(wr_tx_stat && wd[`CCS_TX_DONE_BIT]) |=> o_tx_flags.tx_frame_done
  ) else $error("frame done lost without clear");

  COV_TX_DONE_IRQ: cover property (o_tx_flags.tx_frame_done && irq_en ##1 o_tx_irq);
  COV_RX_FULL:     cover property (o_rx_flags.rx_queue_full && i_rx_ev.byte_push);
  COV_SET_CLEAR:   cover property (set_tx_done && wr_tx_stat && wd[`CCS_TX_DONE_BIT]);
  COV_TIMEOUT:     cover property (tmo_hit);

endmodule : ccs_status_flags

// >>> core/ccs_defines.svh
// Register offsets, bit positions, reset values and timing counts of the status flags.
// Assumes a 40 MHz reference clock and a byte-addressed plain register port.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ============================================================
// Register port widths and offsets
`define CCS_ADDR_W          8
`define CCS_DATA_W          16
`define CCS_TX_STATUS_OFS   8'h10
`define CCS_RX_STATUS_OFS   8'h12
`define CCS_TX_CTRL_OFS     8'h18

// ============================================================
// Transmit status bit positions
`define CCS_TX_DONE_BIT     6
`define CCS_TX_EMPTY_BIT    5
`define CCS_TX_CONTEND_BIT  4
`define CCS_TX_ACKF_BIT     3
`define CCS_TX_UNDER_BIT    2
`define CCS_TX_LOST_BIT     1
`define CCS_TX_IDLE_BIT     0

// ============================================================
// Receive status bit positions
`define CCS_RX_DONE_BIT     6
`define CCS_RX_READY_BIT    5
`define CCS_RX_FULL_BIT     4
`define CCS_RX_NEMPTY_BIT   3
`define CCS_RX_TMO_BIT      2
`define CCS_RX_GLITCH_BIT   1
`define CCS_RX_OVER_BIT     0

// ============================================================
// Control bit positions and reset values
`define CCS_CTRL_IRQEN_BIT  6
`define CCS_TX_STATUS_RST   7'h21
`define CCS_RX_STATUS_RST   7'h00
`define CCS_CTRL_RST        1'h0

// ============================================================
// Depth and timing
`define CCS_RX_DEPTH        16
`define CCS_CLK_MHZ         40
`define CCS_TMO_LIMIT_US    5000
`define CCS_TMO_CYCLES      (`CCS_TMO_LIMIT_US * `CCS_CLK_MHZ)

`endif

// >>> core/ccs_pkg.sv
// Types shared by the status flag logic, the engine model and the bench.
// Assumes the defines header sits on the include path.
`include "ccs_defines.svh"

package ccs_pkg;

  // ============================================================
  // Transmit status, packed in register bit order 6..0
  typedef struct packed {
    logic tx_frame_done;
    logic tx_queue_empty;
    logic contention_error;
    logic acknowledge_fault;
    logic tx_underrun;
    logic lost_arbitration;
    logic bus_idle;
  } ccs_tx_stat_type;

  // ============================================================
  // Receive status, packed in register bit order 6..0
  typedef struct packed {
    logic rx_frame_done;
    logic rx_data_ready;
    logic rx_queue_full;
    logic rx_queue_not_empty;
    logic bus_timeout;
    logic bus_glitch_error;
    logic rx_overrun;
  } ccs_rx_stat_type;

  // ============================================================
  // Events and levels from the transmit engine
  typedef struct packed {
    logic block_sent;          // Pulse: block fully sent
    logic end_of_message_flag; // Level beside block_sent
    logic collide;             // Pulse: line differs from driven value
    logic in_arbitration;      // Level: arbitration phase
    logic ack_sampled;         // Pulse: acknowledge bit sampled
    logic ack_bit;             // Sampled acknowledge value
    logic broadcast;           // Level: frame is broadcast
    logic shift_need;          // Pulse: shift register wants a byte
    logic queue_pop_last;      // Pulse: final queue entry taken
    logic queue_push;          // Pulse: software wrote a block
    logic bus_idle;            // Level: bus idle
  } ccs_tx_event_type;

  // ============================================================
  // Events and levels from the receive engine
  typedef struct packed {
    logic block_taken;         // Pulse: block fully received
    logic end_of_message_flag; // Level beside block_taken
    logic byte_push;           // Pulse: byte moves to the queue
    logic byte_pop;            // Pulse: software read a byte
    logic queue_flush;         // Pulse: queue emptied
    logic glitch;              // Pulse: spurious pulse seen
    logic active;              // Level: reception in progress
    logic line_high;           // Level: bus line high
  } ccs_rx_event_type;

  // ============================================================
  // Register port request
  typedef struct packed {
    logic [`CCS_ADDR_W-1:0] addr;
    logic [`CCS_DATA_W-1:0] wdata;
    logic                   we;
    logic                   re;
  } ccs_reg_req_type;

endpackage : ccs_pkg

// >>> core/ccs_rx_level.sv
// Occupancy tracker of the receive queue: count, next full and next not-empty.
// Assumes push, pop and flush are one-cycle pulses in the reference clock domain.
`timescale 1ns/100ps
`include "ccs_defines.svh"

module ccs_rx_level #(
  parameter int unsigned DEPTH = `CCS_RX_DEPTH,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          i_ref_clk,    // Reference clock
  input  wire logic          i_rst_n,      // Async reset, active low
  input  wire logic          i_push,       // Byte offered to the queue
  input  wire logic          i_pop,        // Byte read out
  input  wire logic          i_flush,      // Queue emptied
  output logic [CW-1:0]      o_count,      // Entries held
  output logic               o_accept,     // Push was stored
  output logic               o_overrun,    // Push met a full queue
  output logic               o_next_full,  // Full after this edge
  output logic               o_next_nempty // Not empty after this edge
);

  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // ============================================================
  // Parameter check
  if (DEPTH < 2) begin : g_depth_chk
    $error("ccs_rx_level: DEPTH below 2");
  end

  logic            full;
  logic            do_pop;
  logic [CW-1:0]   next_count;

  // Push handling and next occupancy
  always_comb begin
    full         = (o_count == DEPTH_C);
    o_accept     = i_push & ~full;
    o_overrun    = i_push & full;
    do_pop       = i_pop & (o_count != '0);
    next_count   = o_count;
    if (i_flush) begin
      next_count = '0;
    end else if (o_accept && !do_pop) begin
      next_count = o_count + CW'(1);
    end else if (do_pop && !o_accept) begin
      next_count = o_count - CW'(1);
    end
    o_next_full   = (next_count == DEPTH_C);
    o_next_nempty = (next_count != '0);
  end

  // Occupancy count
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end

endmodule : ccs_rx_level

// >>> dv/ccs_engine_model.sv
// Bit engine stand-in: turns a scenario code into event pulses that last while the code is held.
// Assumes the code is changed by the bench right after a rising edge.
`timescale 1ns/100ps
module ccs_engine_model (
  input  wire logic [3:0]           i_code,   // Scenario code, see table below
  input  wire logic                 i_bit,    // Ack, arbitration or end of message value
  output ccs_pkg::ccs_tx_event_type o_tx_ev,  // Transmit events
  output ccs_pkg::ccs_rx_event_type o_rx_ev   // Receive events
);
  // ==========
  // Codes: 1 collide, 2/3 directed/broadcast ack, 4 byte in, 5 block sent, 6 block written,
  // 7 last pop, 8 shift need, 9 block taken, A glitch, B line high, C byte read, D flush
  // Pulses last while the code is held; the bus is busy during any event
  always_comb begin
    o_tx_ev = '0;
    o_rx_ev = '0;
    o_tx_ev.bus_idle = (i_code == 4'h0);
    o_tx_ev.collide = (i_code == 4'h1);
    o_tx_ev.in_arbitration = i_bit;
    o_tx_ev.ack_sampled = (i_code[3:1] == 3'h1);
    o_tx_ev.broadcast = i_code[0];
    o_tx_ev.ack_bit = i_bit;
    o_tx_ev.block_sent = (i_code == 4'h5);
    o_tx_ev.end_of_message_flag = i_bit;
    o_tx_ev.queue_push = (i_code == 4'h6);
    o_tx_ev.queue_pop_last = (i_code == 4'h7);
    o_tx_ev.shift_need = (i_code == 4'h8);
    o_rx_ev.byte_push = (i_code == 4'h4);
    o_rx_ev.block_taken = (i_code == 4'h9);
    o_rx_ev.end_of_message_flag = i_bit;
    o_rx_ev.glitch = (i_code == 4'hA);
    o_rx_ev.active = (i_code == 4'hB);
    o_rx_ev.line_high = (i_code == 4'hB);
    o_rx_ev.byte_pop = (i_code == 4'hC);
    o_rx_ev.queue_flush = (i_code == 4'hD);
  end
endmodule : ccs_engine_model

// >>> dv/tb_ccs_status_flags.sv
// Bench for the status flags: engine events in, register reads compared.
// Assumes a receive depth of 4 and a short timeout count.
`timescale 1ns/100ps
module tb_ccs_status_flags;
  logic clk = 0, rst_n = 0, b = 0, irq, abit;
  logic [3:0] code = 0, acode;
  logic [15:0] rdata;
  ccs_pkg::ccs_reg_req_type req = '0;
  ccs_pkg::ccs_tx_event_type tx_ev;
  ccs_pkg::ccs_rx_event_type rx_ev;
  int mismatches = 0, samples_checked = 0, seed = 50, i, cnt = 0;
  always #12.5 clk = ~clk;
  ccs_engine_model u_eng (.i_code(code), .i_bit(b), .o_tx_ev(tx_ev), .o_rx_ev(rx_ev));
  ccs_status_flags #(.RX_DEPTH(4), .TMO_CYCLES(8)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .i_tx_ev(tx_ev), .i_rx_ev(rx_ev), .o_rdata(rdata), .o_tx_flags(), .o_rx_flags(), .o_tx_irq(irq));
  // ==========
  // Bus and event tasks
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    req.addr <= a;
    req.re <= 1'b1;
    @(posedge clk);
    req.re <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.we <= 1'b1;
    @(posedge clk);
    req.we <= 1'b0;
  endtask : wr
  task automatic ev(input logic [3:0] c, input logic v, input int n = 1);
    @(posedge clk);
    code <= c;
    b <= v;
    repeat (n) @(posedge clk);
    code <= 4'h0;
  endtask : ev
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ==========
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h10, 16'h0021);
    rd(8'h12, 16'h0000);
    wr(8'h18, 16'h0040);
    ev(4'h1, 1'b1);
    rd(8'h10, 16'h0063);
    rd(8'h18, 16'h0040);
    chk("irq", 16'h0001, {15'h0, irq});
    wr(8'h10, 16'h007F);
    rd(8'h10, 16'h0021);
    chk("irq", 16'h0000, {15'h0, irq});
    ev(4'h1, 1'b0);
    rd(8'h10, 16'h0071);
    for (i = 0; i < 6; i++) begin
      wr(8'h10, 16'h007F);
      acode = 4'h2 + 4'($random(seed) & 1);
      abit = 1'($random(seed));
      ev(acode, abit);
      rd(8'h10, (acode[0] ? ~abit : abit) ? 16'h0069 : 16'h0021);
    end
    // Frame end, interrupt gate off, underrun and queue empty
    wr(8'h18, 16'h0000);
    wr(8'h10, 16'h007F);
    ev(4'h5, 1'b0);
    rd(8'h10, 16'h0021);
    ev(4'h5, 1'b1);
    rd(8'h10, 16'h0061);
    chk("irq", 16'h0000, {15'h0, irq});
    rd(8'h18, 16'h0000);
    wr(8'h10, 16'h007F);
    ev(4'h8, 1'b0);
    rd(8'h10, 16'h0065);
    wr(8'h10, 16'h007F);
    ev(4'h6, 1'b0);
    rd(8'h10, 16'h0001);
    ev(4'h8, 1'b0);
    rd(8'h10, 16'h0001);
    ev(4'h7, 1'b0);
    rd(8'h10, 16'h0021);
    for (i = 1; i <= 5; i++) begin
      ev(4'h4, 1'b0);
      cnt = (cnt < 4) ? cnt + 1 : cnt;
      rd(8'h12, (i > 4) ? 16'h0079 : (cnt == 4) ? 16'h0038 : 16'h0028);
    end
    wr(8'h12, 16'h007F);
    rd(8'h12, 16'h0018);
    // Line held high up to and one past the limit, glitch, block end, pop and flush
    ev(4'hB, 1'b1, 8);
    rd(8'h12, 16'h0018);
    ev(4'hB, 1'b1, 9);
    rd(8'h12, 16'h005C);
    wr(8'h12, 16'h007F);
    ev(4'hA, 1'b0);
    rd(8'h12, 16'h005A);
    wr(8'h12, 16'h007F);
    ev(4'h9, 1'b0);
    rd(8'h12, 16'h0018);
    ev(4'h9, 1'b1);
    rd(8'h12, 16'h0058);
    ev(4'hC, 1'b0);
    rd(8'h12, 16'h0048);
    ev(4'hD, 1'b0);
    rd(8'h12, 16'h0040);
    rd(8'h14, 16'h0000);
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : tb_ccs_status_flags
